// ===== hdl/ssnp_cfg.svh
// Constants for the SMBus host command, block FIFO, host-as-slave and snoop block.
// Assumes inclusion by bare name from each design file that needs it.
//
// What this block does
// - Command register value is handed to the host engine as the command field.
// - Any block transfer error empties the block FIFO by hardware.
// - FIFO port reads and writes are ignored while the host is busy.
// - Data sent to our own slave address is latched into the data capture.
// - Snoop-matched cycles are taken as write word; data goes to capture.
// - Snoop cycle: command bit 0 to address bit 0, bits 7:1 to 7:1.
// - Own-address cycle: command-phase device address goes to address bits 7:1.
// - Own-address cycle with device address 11110xx stores the second address byte in bits 15:8.
// - Own match needs equal 7-bit address and write direction; then write word.
// - Own match captures address and data; status event after cycle completes.
// - Snoop compares address for reads and writes; event after cycle completes.
// - No snoop event when snoop address equals own slave address.
// - Own slave address register resets to 10h.
// - Snoop address register resets to 10h, bit 0 reserved.
// - Host start is accepted only while the host is not busy.
`ifndef SSNP_CFG_SVH
`define SSNP_CFG_SVH

// Register offsets
`define SSNP_OFS_CMD 8'hE8
`define SSNP_OFS_FIFO 8'hE9
`define SSNP_OFS_DATA_LO 8'hEA
`define SSNP_OFS_DATA_HI 8'hEB
`define SSNP_OFS_ADDR_LO 8'hEC
`define SSNP_OFS_ADDR_HI 8'hED
`define SSNP_OFS_OWN 8'hEE
`define SSNP_OFS_SNOOP 8'hEF

// Reset values
`define SSNP_RST_CMD 8'h00
`define SSNP_RST_OWN 8'h10
`define SSNP_RST_SNOOP 8'h10
`define SSNP_RST_WORD 16'h0000
`define SSNP_RST_BYTE 8'h00

// FIFO sizing
`define SSNP_FIFO_ENTRIES 32
`define SSNP_FIFO_DEPTH 6'h20
`define SSNP_PTR_ONE 5'h01
`define SSNP_CNT_ONE 6'h01

// Bit framing
`define SSNP_LAST_BIT 3'h7
`define SSNP_BIT_ONE 3'h1
`define SSNP_TEN_BIT_PREFIX 5'h1E

`endif

// ===== hdl/ssnp_pkg.sv
// Types shared by the SMBus command, FIFO and slave capture block.
// Assumes no other package; constants live in ssnp_cfg.svh.
package ssnp_pkg;

  // Register port request, one access per cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ssnp_io_req_t;

  // Captured slave cycle
  typedef struct packed {
    logic [15:0] data;
    logic [15:0] devAddr;
  } ssnp_capture_t;

  typedef enum logic [1:0] {
    MON_IDLE,
    MON_BITS,
    MON_ACK,
    MON_SKIP
  } ssnp_mon_state_t;

  typedef enum logic [2:0] {
    FIELD_CMD,
    FIELD_SECOND,
    FIELD_DLO,
    FIELD_DHI,
    FIELD_DONE
  } ssnp_field_t;

endpackage : ssnp_pkg

// ===== hdl/ssnp_fifo.sv
// Block data FIFO, 32 bytes, with flush.
// Assumes the caller multiplexes software and engine access onto one port.
`timescale 1ns/1ps
`default_nettype none
`include "ssnp_cfg.svh"
module ssnp_fifo
  import ssnp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Control
  input wire logic flush,
  input wire logic wrEn,
  input wire logic [7:0] wrData,
  input wire logic rdEn,
  // Status and head
  output logic [7:0] rdData,
  output logic [5:0] countQ,
  output logic notFullQ,
  output logic notEmptyQ
);

  logic [7:0] mem [`SSNP_FIFO_ENTRIES];
  logic [4:0] wrPtrQ;
  logic [4:0] rdPtrQ;
  logic doWr;
  logic doRd;
  logic [5:0] countD;

  assign doWr = wrEn && notFullQ;
  assign doRd = rdEn && notEmptyQ;
  assign rdData = mem[rdPtrQ];

  always_comb begin
    countD = countQ;
    if (flush) begin
      countD = 6'h00;
    end else if (doWr && !doRd) begin
      countD = countQ + `SSNP_CNT_ONE;
    end else if (doRd && !doWr) begin
      countD = countQ - `SSNP_CNT_ONE;
    end
  end

  // Storage
  always_ff @(posedge clock) begin
    if (clkEn && doWr && !flush) begin
      mem[wrPtrQ] <= wrData;
    end
  end

  // Pointers and count
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wrPtrQ <= 5'h00;
      rdPtrQ <= 5'h00;
      countQ <= 6'h00;
      notFullQ <= 1'b1;
      notEmptyQ <= 1'b0;
    end else if (clkEn) begin
      if (flush) begin
        wrPtrQ <= 5'h00;
        rdPtrQ <= 5'h00;
      end else begin
        if (doWr) begin
          wrPtrQ <= wrPtrQ + `SSNP_PTR_ONE;
        end
        if (doRd) begin
          rdPtrQ <= rdPtrQ + `SSNP_PTR_ONE;
        end
      end
      countQ <= countD;
      notFullQ <= (countD != `SSNP_FIFO_DEPTH);
      notEmptyQ <= (countD != 6'h00);
    end
  end

  chk_fifo_flush_empty: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && flush |=> countQ == 6'h00 && !notEmptyQ)
    else $error("FIFO not empty after flush");

  chk_fifo_depth_bound: assert property (@(posedge clock) disable iff (sys_rst)
    countQ <= `SSNP_FIFO_DEPTH && (notFullQ == (countQ != `SSNP_FIFO_DEPTH)))
    else $error("FIFO count beyond depth or full flag wrong");

endmodule : ssnp_fifo
`default_nettype wire

// ===== hdl/ssnp_skid.sv
// Two-entry buffer between the block FIFO and the host engine.
// Assumes valid/ready on both sides; a flush drops both entries.
`timescale 1ns/1ps
`default_nettype none
module ssnp_skid
  import ssnp_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic flush,
  // Fill side
  input wire logic inValid,
  input wire logic [7:0] inData,
  output logic inReadyQ,
  // Drain side
  output logic outValidQ,
  output logic [7:0] outDataQ,
  input wire logic outReady
);

  logic [7:0] spareQ;
  logic spareValidQ;
  logic push;
  logic pop;

  assign push = inValid && inReadyQ;
  assign pop = outValidQ && outReady;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      outValidQ <= 1'b0;
      spareValidQ <= 1'b0;
      outDataQ <= 8'h00;
      spareQ <= 8'h00;
      inReadyQ <= 1'b1;
    end else if (clkEn) begin
      if (flush) begin
        outValidQ <= 1'b0;
        spareValidQ <= 1'b0;
        inReadyQ <= 1'b1;
      end else begin
        if (pop && push) begin
          if (spareValidQ) begin
            outDataQ <= spareQ;
            spareQ <= inData;
          end else begin
            outDataQ <= inData;
          end
        end else if (pop) begin
          outDataQ <= spareQ;
          outValidQ <= spareValidQ;
          spareValidQ <= 1'b0;
          inReadyQ <= 1'b1;
        end else if (push) begin
          if (!outValidQ) begin
            outDataQ <= inData;
            outValidQ <= 1'b1;
          end else begin
            spareQ <= inData;
            spareValidQ <= 1'b1;
            inReadyQ <= 1'b0;
          end
        end
      end
    end
  end

  chk_skid_stall_hold: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && !flush && outValidQ && !outReady |=> outValidQ && $stable(outDataQ))
    else $error("Buffered word lost under stall");

endmodule : ssnp_skid
`default_nettype wire

// ===== hdl/ssnp_top.sv
// SMBus host command byte, block FIFO port, host-as-slave capture and snoop match.
// Assumes a host engine on the same clock drives busy, start and FIFO streams;
// SMBus pins arrive asynchronously and are resolved by the surroundings.
`timescale 1ns/1ps
`default_nettype none
`include "ssnp_cfg.svh"
module ssnp_top
  import ssnp_pkg::*;
(
  // Clock, reset, enable
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clkEn,
  // Register port
  input wire ssnp_io_req_t ioReq,
  output logic [7:0] ioRdataQ,
  output logic ioRdValidQ,
  // Host engine control
  input wire logic hostStartReq,
  input wire logic hostBusy,
  input wire logic blockReadSel,
  input wire logic engineBlockWrite,
  input wire logic engineError,
  output logic hostStartGoQ,
  output logic [7:0] hostCommandFieldQ,
  // Block write stream to engine
  output logic [7:0] txDataQ,
  output logic txValidQ,
  input wire logic txReady,
  // Block read stream from engine
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  output logic rxReadyQ,
  // SMBus pins
  input wire logic sclPin,
  input wire logic sdaPin,
  output logic sdaOutQ,
  output logic sdaOeQ,
  // Match events
  output logic slaveMatchEventQ,
  output logic snoopMatchEventQ
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic regHit(input logic [7:0] addr, input logic [7:0] ofs);
    regHit = (addr == ofs);
  endfunction : regHit

  function automatic logic addrHit(input logic [7:0] busByte, input logic [7:0] refByte);
    addrHit = (busByte[7:1] == refByte[7:1]);
  endfunction : addrHit

  // ----------------------------------------------------------------
  // Pin synchronisers and bus events
  // ----------------------------------------------------------------
  logic sclS1, sclS2, sclPrev;
  logic sdaS1, sdaS2, sdaPrev;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sclS1 <= 1'b1;
      sclS2 <= 1'b1;
      sclPrev <= 1'b1;
      sdaS1 <= 1'b1;
      sdaS2 <= 1'b1;
      sdaPrev <= 1'b1;
    end else if (clkEn) begin
      sclS1 <= sclPin;
      sclS2 <= sclS1;
      sclPrev <= sclS2;
      sdaS1 <= sdaPin;
      sdaS2 <= sdaS1;
      sdaPrev <= sdaS2;
    end
  end

  logic sclRise, sclFall, busStart, busStop;
  assign sclRise = sclS2 && !sclPrev;
  assign sclFall = !sclS2 && sclPrev;
  assign busStart = sclS2 && sclPrev && sdaPrev && !sdaS2;
  assign busStop = sclS2 && sclPrev && !sdaPrev && sdaS2;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ownAddrQ;
  logic [7:0] snoopAddrQ;
  ssnp_capture_t capQ;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hostCommandFieldQ <= `SSNP_RST_CMD;
      ownAddrQ <= `SSNP_RST_OWN;
      snoopAddrQ <= `SSNP_RST_SNOOP;
    end else if (clkEn && ioReq.wr) begin
      if (regHit(ioReq.addr, `SSNP_OFS_CMD)) begin
        hostCommandFieldQ <= ioReq.wdata;
      end
      if (regHit(ioReq.addr, `SSNP_OFS_OWN)) begin
        ownAddrQ <= {ioReq.wdata[7:1], 1'b0};
      end
      if (regHit(ioReq.addr, `SSNP_OFS_SNOOP)) begin
        snoopAddrQ <= {ioReq.wdata[7:1], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Block FIFO and buffer
  // ----------------------------------------------------------------
  logic swFifoWr, swFifoRd, engPush, skidFill, skidInValid, skidInReady;
  logic fifoFlush, fifoNotFull, fifoNotEmpty;
  logic [7:0] fifoHead;
  logic [5:0] fifoCount;

  assign swFifoWr = ioReq.wr && regHit(ioReq.addr, `SSNP_OFS_FIFO) && !hostBusy;
  assign swFifoRd = ioReq.rd && regHit(ioReq.addr, `SSNP_OFS_FIFO) && !hostBusy;
  assign engPush = hostBusy && rxValid;
  assign skidInValid = hostBusy && engineBlockWrite && fifoNotEmpty;
  assign skidFill = skidInValid && skidInReady;
  assign fifoFlush = engineError || (hostStartGoQ && blockReadSel);

  ssnp_fifo u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .flush(fifoFlush),
    .wrEn(swFifoWr || engPush),
    .wrData(hostBusy ? rxData : ioReq.wdata),
    .rdEn(swFifoRd || skidFill),
    .rdData(fifoHead),
    .countQ(fifoCount),
    .notFullQ(fifoNotFull),
    .notEmptyQ(fifoNotEmpty)
  );

  ssnp_skid u_skid (
    .clock(clock),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .flush(fifoFlush),
    .inValid(skidInValid),
    .inData(fifoHead),
    .inReadyQ(skidInReady),
    .outValidQ(txValidQ),
    .outDataQ(txDataQ),
    .outReady(txReady)
  );

  assign rxReadyQ = fifoNotFull;

  // ----------------------------------------------------------------
  // Read path and host start
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ioRdataQ <= `SSNP_RST_BYTE;
      ioRdValidQ <= 1'b0;
    end else if (clkEn) begin
      ioRdValidQ <= ioReq.rd;
      case (ioReq.addr)
        `SSNP_OFS_CMD: ioRdataQ <= hostCommandFieldQ;
        `SSNP_OFS_FIFO: ioRdataQ <= swFifoRd ? fifoHead : `SSNP_RST_BYTE;
        `SSNP_OFS_DATA_LO: ioRdataQ <= capQ.data[7:0];
        `SSNP_OFS_DATA_HI: ioRdataQ <= capQ.data[15:8];
        `SSNP_OFS_ADDR_LO: ioRdataQ <= capQ.devAddr[7:0];
        `SSNP_OFS_ADDR_HI: ioRdataQ <= capQ.devAddr[15:8];
        `SSNP_OFS_OWN: ioRdataQ <= ownAddrQ;
        `SSNP_OFS_SNOOP: ioRdataQ <= snoopAddrQ;
        default: ioRdataQ <= `SSNP_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hostStartGoQ <= 1'b0;
    end else if (clkEn) begin
      hostStartGoQ <= hostStartReq && !hostBusy;
    end
  end

  // ----------------------------------------------------------------
  // Bus monitor
  // ----------------------------------------------------------------
  ssnp_mon_state_t monStateQ;
  ssnp_field_t fieldQ;
  logic [2:0] bitCntQ;
  logic [7:0] shiftQ;
  logic ownQ, snoopQ, addrPhaseQ, reAddrQ;
  logic byteDone, ownHit, snoopHit, active;
  logic [7:0] busByte;

  assign active = ownQ || snoopQ;
  assign byteDone = (monStateQ == MON_BITS) && sclRise && (bitCntQ == `SSNP_LAST_BIT);
  assign busByte = {shiftQ[6:0], sdaS2};
  assign ownHit = addrHit(busByte, ownAddrQ) && !busByte[0];
  assign snoopHit = addrHit(busByte, snoopAddrQ) && !addrHit(snoopAddrQ, ownAddrQ);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      monStateQ <= MON_IDLE;
      fieldQ <= FIELD_CMD;
      bitCntQ <= 3'h0;
      shiftQ <= 8'h00;
      ownQ <= 1'b0;
      snoopQ <= 1'b0;
      addrPhaseQ <= 1'b0;
      reAddrQ <= 1'b0;
    end else if (clkEn) begin
      if (busStart) begin
        monStateQ <= MON_BITS;
        bitCntQ <= 3'h0;
        addrPhaseQ <= 1'b1;
        reAddrQ <= active;
      end else if (busStop) begin
        monStateQ <= MON_IDLE;
        fieldQ <= FIELD_CMD;
        ownQ <= 1'b0;
        snoopQ <= 1'b0;
        reAddrQ <= 1'b0;
      end else begin
        case (monStateQ)
          MON_BITS: begin
            if (sclRise) begin
              shiftQ <= busByte;
              bitCntQ <= bitCntQ + `SSNP_BIT_ONE;
            end
            if (byteDone) begin
              monStateQ <= MON_ACK;
              if (addrPhaseQ) begin
                addrPhaseQ <= 1'b0;
                if (!reAddrQ) begin
                  ownQ <= ownHit;
                  snoopQ <= snoopHit && !ownHit;
                end
              end else if (active) begin
                case (fieldQ)
                  FIELD_CMD: begin
                    fieldQ <= (ownQ && busByte[7:3] == `SSNP_TEN_BIT_PREFIX) ?
                      FIELD_SECOND : FIELD_DLO;
                  end
                  FIELD_SECOND: fieldQ <= FIELD_DLO;
                  FIELD_DLO: fieldQ <= FIELD_DHI;
                  FIELD_DHI: fieldQ <= FIELD_DONE;
                  default: fieldQ <= FIELD_DONE;
                endcase
              end
            end
          end
          MON_ACK: begin
            if (sclRise) begin
              monStateQ <= active ? MON_BITS : MON_SKIP;
            end
          end
          MON_SKIP: monStateQ <= MON_SKIP;
          default: monStateQ <= MON_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Capture and completion
  // ----------------------------------------------------------------
  ssnp_capture_t pendQ;
  logic commit;

  // Stop condition always follows one clock rise after the last acknowledge
  assign commit = busStop && active && (fieldQ == FIELD_DONE) &&
    (monStateQ == MON_BITS) && (bitCntQ == `SSNP_BIT_ONE);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pendQ <= {`SSNP_RST_WORD, `SSNP_RST_WORD};
    end else if (clkEn && byteDone && !addrPhaseQ && active) begin
      case (fieldQ)
        FIELD_CMD: begin
          if (snoopQ) begin
            pendQ.devAddr <= {`SSNP_RST_BYTE, busByte};
          end else begin
            pendQ.devAddr <= {`SSNP_RST_BYTE, busByte[7:1], 1'b0};
          end
        end
        FIELD_SECOND: pendQ.devAddr[15:8] <= busByte;
        FIELD_DLO: pendQ.data[7:0] <= busByte;
        FIELD_DHI: pendQ.data[15:8] <= busByte;
        default: pendQ <= pendQ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      capQ <= {`SSNP_RST_WORD, `SSNP_RST_WORD};
      slaveMatchEventQ <= 1'b0;
      snoopMatchEventQ <= 1'b0;
    end else if (clkEn) begin
      if (commit) begin
        capQ <= pendQ;
      end
      slaveMatchEventQ <= commit && ownQ;
      snoopMatchEventQ <= commit && snoopQ;
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge drive for own address
  // ----------------------------------------------------------------
  logic ackPendQ;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ackPendQ <= 1'b0;
      sdaOeQ <= 1'b0;
      sdaOutQ <= 1'b0;
    end else if (clkEn) begin
      if (busStart || busStop) begin
        ackPendQ <= 1'b0;
        sdaOeQ <= 1'b0;
      end else begin
        if (byteDone) begin
          ackPendQ <= addrPhaseQ ? (ownHit && !reAddrQ) : ownQ;
        end
        if (sclFall && monStateQ == MON_ACK && ackPendQ) begin
          sdaOeQ <= 1'b1;
          ackPendQ <= 1'b0;
        end else if (sclFall && monStateQ == MON_BITS) begin
          sdaOeQ <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_cmd_field_load: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && ioReq.wr && ioReq.addr == `SSNP_OFS_CMD |=>
      hostCommandFieldQ == $past(ioReq.wdata))
    else $error("Command field not loaded");

  chk_busy_read_ignored: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && hostBusy && ioReq.rd && ioReq.addr == `SSNP_OFS_FIFO |=>
      ioRdataQ == `SSNP_RST_BYTE && fifoCount == $past(fifoCount) + (rxReadyQ ? 6'h00 : 6'h00)
      || $past(engPush) || $past(skidFill) || $past(fifoFlush))
    else $error("FIFO port read while busy took effect");

  chk_start_gate_busy: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(hostStartGoQ) |-> $past(hostStartReq) && !$past(hostBusy))
    else $error("Host start accepted while busy");

  chk_snoop_not_own: assert property (@(posedge clock) disable iff (sys_rst)
    snoopMatchEventQ |-> !slaveMatchEventQ && $past(snoopQ) && !$past(ownQ))
    else $error("Snoop event on own-address cycle");

  chk_reset_addr_values: assert property (@(posedge clock)
    $past(sys_rst) |-> ownAddrQ == `SSNP_RST_OWN && snoopAddrQ == `SSNP_RST_SNOOP)
    else $error("Address registers wrong after reset");

  chk_capture_on_event: assert property (@(posedge clock) disable iff (sys_rst)
    slaveMatchEventQ || snoopMatchEventQ |-> capQ == $past(pendQ))
    else $error("Capture does not match completed cycle");

  chk_ack_own_only: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(sdaOeQ) |-> ownQ && monStateQ == MON_ACK)
    else $error("Acknowledge driven without own match");

  chk_error_flush_buffer: assert property (@(posedge clock) disable iff (sys_rst)
    clkEn && engineError |=> !txValidQ && fifoCount == 6'h00)
    else $error("Error did not flush block data");

endmodule : ssnp_top
`default_nettype wire

// ===== bench/ssnp_smbus_master.sv
// SMBus master model for the host-as-slave and snoop logic.
// Assumes pulled-up wires resolved by the bench; clock stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module ssnp_smbus_master (
  // Wires
  output logic scl,
  output logic sdaDrv,
  input wire logic sdaWire
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  // Data moves only while the clock is low
  task automatic put1(input logic b, output logic seen);
    #20;
    sdaDrv = b;
    #230;
    scl = 1'b1;
    #100;
    seen = sdaWire;
    #50;
    scl = 1'b0;
  endtask : put1
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put1(d[i], s);
    put1(1'b1, ack);
  endtask : put
  task automatic start();
    #213;
    sdaDrv = 1'b0;
    #200;
    scl = 1'b0;
  endtask : start
  task automatic stop();
    #20;
    sdaDrv = 1'b0;
    #230;
    scl = 1'b1;
    #200;
    sdaDrv = 1'b1;
    #400;
  endtask : stop
endmodule : ssnp_smbus_master
`default_nettype wire

// ===== bench/tb_ssnp_top.sv
// Self-checking bench for the command, block FIFO and slave capture block.
// Assumes ssnp_pkg and the master model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_ssnp_top;
  import ssnp_pkg::*;
  logic clock, rst, hostStartReq, hostBusy, blockReadSel, engineBlockWrite, engineError;
  logic txReady, rxValid, sclPin, sdaDrv, sdaWire, hostStartGoQ, txValidQ, rxReadyQ, ack;
  logic sdaOutQ, sdaOeQ, slaveEv, snoopEv, ioRdValidQ;
  logic [7:0] rxData, ioRdataQ, hostCommandFieldQ, txDataQ, v, c;
  logic [6:0] own7, snp7;
  logic [15:0] w;
  logic [31:0] seed = 32'h0000_d2fe;
  logic [7:0] b [32];
  ssnp_io_req_t ioReq;
  int fails = 0, nChecks = 0, nSlv = 0, nSnp = 0, cyc = 0, k;
  assign sdaWire = sdaDrv & ~(sdaOeQ & ~sdaOutQ);
  ssnp_top i_ssnp_top (.clock(clock), .sys_rst(rst), .clkEn(1'b1), .ioReq(ioReq),
    .ioRdataQ(ioRdataQ), .ioRdValidQ(ioRdValidQ), .hostStartReq(hostStartReq),
    .hostBusy(hostBusy), .blockReadSel(blockReadSel), .engineBlockWrite(engineBlockWrite),
    .engineError(engineError), .hostStartGoQ(hostStartGoQ),
    .hostCommandFieldQ(hostCommandFieldQ), .txDataQ(txDataQ), .txValidQ(txValidQ),
    .txReady(txReady), .rxData(rxData), .rxValid(rxValid), .rxReadyQ(rxReadyQ),
    .sclPin(sclPin), .sdaPin(sdaWire), .sdaOutQ(sdaOutQ), .sdaOeQ(sdaOeQ),
    .slaveMatchEventQ(slaveEv), .snoopMatchEventQ(snoopEv));
  ssnp_smbus_master i_ssnp_smbus_master (.scl(sclPin), .sdaDrv(sdaDrv), .sdaWire(sdaWire));
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(negedge clock) begin
    nSlv += int'(slaveEv);
    nSnp += int'(snoopEv);
    cyc++;
    if (cyc == 30000) begin
      fails++;
      summarize();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction : rnd
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic ioWr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    ioReq = '{1'b1, 1'b0, a, d};
    @(negedge clock);
    ioReq = '0;
  endtask : ioWr
  task automatic ioRd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    ioReq = '{1'b0, 1'b1, a, 8'h00};
    @(negedge clock);
    ioReq = '0;
    d = ioRdataQ;
    check(16'(ioRdValidQ), 16'h0001);
  endtask : ioRd
  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    ioRd(a, d[7:0]);
    ioRd(a + 8'h01, d[15:8]);
  endtask : rd16
  task automatic hostStart(input logic rdSel);
    @(negedge clock);
    hostStartReq = 1'b1;
    blockReadSel = rdSel;
    @(negedge clock);
    check(16'(hostStartGoQ), 16'h0001);
    hostBusy = 1'b1;
    @(negedge clock);
    @(negedge clock);
    hostStartReq = 1'b0;
    check(16'(hostStartGoQ), 16'h0000);
  endtask : hostStart
  task automatic smbCase(input logic [6:0] tgt, input logic rw, input logic [7:0] d0,
    input logic [7:0] d1, input logic expSlv, input logic expSnp);
    logic [7:0] lo, hi;
    logic ten;
    int s0, p0;
    lo = rnd();
    hi = rnd();
    s0 = nSlv;
    p0 = nSnp;
    ten = expSlv && d0[7:3] == 5'b11110;
    i_ssnp_smbus_master.start();
    i_ssnp_smbus_master.put({tgt, rw}, ack);
    check(16'(ack), 16'(!expSlv));
    i_ssnp_smbus_master.put(d0, ack);
    if (ten) i_ssnp_smbus_master.put(d1, ack);
    i_ssnp_smbus_master.put(lo, ack);
    i_ssnp_smbus_master.put(hi, ack);
    i_ssnp_smbus_master.stop();
    repeat (8) @(negedge clock);
    check(16'(nSlv - s0), 16'(expSlv));
    check(16'(nSnp - p0), 16'(expSnp));
    if (expSlv || expSnp) begin
      rd16(8'hEA, w);
      check(w, {hi, lo});
      rd16(8'hEC, w);
      check(w, expSlv ? {ten ? d1 : 8'h00, d0[7:1], 1'b0} : {8'h00, d0});
    end
  endtask : smbCase
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst, hostStartReq, hostBusy, blockReadSel, engineBlockWrite, engineError} = 6'h20;
    {txReady, rxValid, rxData} = '0;
    ioReq = '0;
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    ioWr(8'hEA, rnd());
    foreach (b[i]) b[i] = 8'h00;
    b[1] = 8'h10;
    b[2] = 8'h10;
    foreach (b[i]) if (i < 8) begin
      ioRd(8'hE8 + ((8'(i) * 8'h06 + 8'h06) % 8'h08), v);
    end
    ioRd(8'hE8, v);
    check(16'(v), 16'h0000);
    ioRd(8'hEE, v);
    check(16'(v), 16'h0010);
    ioRd(8'hEF, v);
    check(16'(v), 16'h0010);
    rd16(8'hEA, w);
    check(w, 16'h0000);
    ioRd(8'hE0, v);
    check(16'(v), 16'h0000);
    c = rnd();
    ioWr(8'hE8, c);
    check(16'(hostCommandFieldQ), 16'(c));
    foreach (b[i]) begin
      b[i] = rnd();
      ioWr(8'hE9, b[i]);
    end
    hostStart(1'b0);
    ioWr(8'hE9, 8'hA5);
    ioRd(8'hE9, v);
    check(16'(v), 16'h0000);
    engineBlockWrite = 1'b1;
    k = 0;
    repeat (200) begin
      @(negedge clock);
      txReady = rnd() > 8'h7F;
      if (txValidQ && txReady) begin
        check(16'(txDataQ), 16'(b[k]));
        k++;
      end
    end
    {engineBlockWrite, hostBusy, txReady} = 3'h0;
    check(16'(k), 16'h0020);
    ioWr(8'hE9, rnd());
    hostStart(1'b1);
    for (int i = 0; i < 32; i++) begin
      @(negedge clock);
      b[i] = rnd();
      rxData = b[i];
      rxValid = 1'b1;
      while (!rxReadyQ) @(negedge clock);
    end
    @(negedge clock);
    rxValid = 1'b0;
    hostBusy = 1'b0;
    for (int i = 0; i < 32; i++) begin
      ioRd(8'hE9, v);
      check(16'(v), 16'(b[i]));
    end
    ioWr(8'hE9, rnd());
    @(negedge clock);
    {hostBusy, engineError} = 2'h3;
    @(negedge clock);
    {hostBusy, engineError} = 2'h0;
    c = rnd();
    ioWr(8'hE9, c);
    ioRd(8'hE9, v);
    check(16'(v), 16'(c));
    v = rnd();
    own7 = {2'b01, v[4:0]};
    snp7 = {2'b10, v[4:0]};
    ioWr(8'hEE, {own7, 1'b1});
    ioRd(8'hEE, v);
    check(16'(v), 16'({own7, 1'b0}));
    v = rnd();
    smbCase(own7, 1'b0, {1'b0, v[5:0], 1'b0}, 8'h00, 1'b1, 1'b0);
    smbCase(own7, 1'b1, rnd(), rnd(), 1'b0, 1'b0);
    smbCase(own7, 1'b0, {5'b11110, v[1:0], 1'b0}, rnd(), 1'b1, 1'b0);
    ioWr(8'hEF, {snp7, 1'b0});
    smbCase(snp7, 1'b0, rnd(), rnd(), 1'b0, 1'b1);
    smbCase(snp7, 1'b1, rnd(), rnd(), 1'b0, 1'b1);
    ioWr(8'hEF, {own7, 1'b0});
    smbCase(own7, 1'b0, {1'b0, v[5:0], 1'b0}, 8'h00, 1'b1, 1'b0);
    summarize();
  end
endmodule : tb_ssnp_top
`default_nettype wire
